// File: src/dac_clear_pkg.sv
// Constants and types shared by the clear-pin and data-ready block
package dac_clear_pkg;
  localparam int NUM_CHAN = 12;
  localparam int DAC_WIDTH = 12;
  localparam int ADDR_WIDTH = 8;
  localparam int CLK_MHZ = 125;
  // Time for one conversion cycle, in ns
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  // Width of the auto-mode ready pulse, in ns
  localparam int PULSE_TIME_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS * CLK_MHZ) / 1000;
  localparam int CNT_WIDTH = 9;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] GROUP_OFFSET = 8'h04;
  localparam logic [7:0] CODE_OFFSET = 8'h08;
  localparam logic [7:0] LOAD_OFFSET = 8'h0c;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h14;
  localparam logic [7:0] GPIO_OFFSET = 8'h18;
  localparam logic [7:0] STATUS_OFFSET = 8'h1c;
  localparam logic [7:0] RESULT_OFFSET = 8'h20;
  localparam logic [7:0] DATA_BASE = 8'h40;
  localparam logic [7:0] LATCH_BASE = 8'h80;
  // Control register fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_READY_EN_BIT = 1;
  localparam int CTRL_SENSOR2_EN_BIT = 2;
  localparam int CTRL_SYNC_LOAD_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  // Event bits of status and mask
  localparam int EV_CONV_DONE = 0;
  localparam int EV_CLEAR_A = 1;
  localparam int EV_CLEAR_B = 2;
  localparam int EV_WIDTH = 3;
  // Reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h2;
  localparam logic [NUM_CHAN-1:0] GROUP_RESET = 12'h000;
  localparam logic [DAC_WIDTH-1:0] CODE_RESET = 12'h000;
  localparam logic [DAC_WIDTH-1:0] DATA_RESET = 12'h000;
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 3'h0;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONVERT = 2'b01
  } seq_state_t;
endpackage : dac_clear_pkg

// File: src/adc_sequencer.sv
// Conversion timing and data-ready pin generation
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer
  import dac_clear_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic trigger_fall, // Synchronised trigger falling edge
  input wire logic auto_mode, // Repeat conversions
  input wire logic ready_enable, // Ready indication active
  input wire logic result_read, // Result register read
  output logic busy, // Conversion in progress
  output logic conv_done, // End of a conversion cycle
  output logic result_ready_n // Data-ready pin, active low
);
  seq_state_t state;
  logic [CNT_WIDTH-1:0] conv_cnt;
  logic [CNT_WIDTH-1:0] pulse_cnt;
  logic hold_ready;
  logic end_cycle;

  assign end_cycle = (state == SEQ_CONVERT) && (conv_cnt == CNT_WIDTH'(CONV_CYCLES - 1));
  assign busy = (state == SEQ_CONVERT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
      conv_cnt <= '0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          conv_cnt <= '0;
          if (trigger_fall) begin
            state <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          if (end_cycle) begin
            conv_cnt <= '0;
            if (!auto_mode) begin
              state <= SEQ_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        default: begin
          state <= SEQ_IDLE;
          conv_cnt <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done <= 1'b0;
    end else begin
      conv_done <= end_cycle;
    end
  end

  // Direct mode: held until the result is read; a new end wins over the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ready <= 1'b0;
    end else if (conv_done && !auto_mode) begin
      hold_ready <= 1'b1;
    end else if (result_read || auto_mode) begin
      hold_ready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (conv_done && auto_mode) begin
      pulse_cnt <= CNT_WIDTH'(PULSE_CYCLES);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_n <= 1'b1;
    end else if (!ready_enable) begin
      result_ready_n <= 1'b1;
    end else if (auto_mode) begin
      result_ready_n <= !((conv_done) || (pulse_cnt > CNT_WIDTH'(1)));
    end else begin
      result_ready_n <= !(hold_ready || (conv_done));
    end
  end
endmodule : adc_sequencer
`default_nettype wire

// File: src/dac_clear_ctrl.sv
// DAC clear pins, data-ready pin and shared sensor pin with APB registers
`timescale 1ns/1ps
`default_nettype none
module dac_clear_ctrl
  import dac_clear_pkg::*;
(
  input wire logic pclk, // Clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic clear_group_a_n, // Clear pin A, active low
  input wire logic clear_group_b_n, // Clear pin B, active low
  input wire logic conversion_trigger_n, // Conversion trigger, active low
  input wire logic [DAC_WIDTH-1:0] adc_data, // Sample value from converter
  output logic result_ready_n, // Data-ready pin, active low
  input wire logic sensor2_pos_or_gpio_in, // Shared pin level
  output logic sensor2_pos_or_gpio_out, // Shared pin drive value
  output logic sensor2_pos_or_gpio_oe_n, // Shared pin enable, low drives
  output logic sensor2_active, // Pin routed to remote sensor
  output logic [NUM_CHAN*DAC_WIDTH-1:0] dac_latch_flat, // Output latch codes
  output logic irq // Interrupt, active high level
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_bank(input logic [ADDR_WIDTH-1:0] addr,
                                   input logic [ADDR_WIDTH-1:0] base);
    logic [ADDR_WIDTH-1:0] off;
    off = addr - base;
    return (addr >= base) && (off[1:0] == 2'b00) && (off[ADDR_WIDTH-1:2] < NUM_CHAN);
  endfunction : in_bank

  function automatic logic [3:0] bank_index(input logic [ADDR_WIDTH-1:0] addr,
                                            input logic [ADDR_WIDTH-1:0] base);
    logic [ADDR_WIDTH-1:0] off;
    off = addr - base;
    return off[5:2];
  endfunction : bank_index

  ////////////////////////////////////////////////////////////////////////////
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [NUM_CHAN-1:0] group_sel;
  logic [DAC_WIDTH-1:0] clear_code;
  logic [EV_WIDTH-1:0] int_status;
  logic [EV_WIDTH-1:0] int_mask;
  logic gpio_drive;
  logic [DAC_WIDTH-1:0] result;
  logic [DAC_WIDTH-1:0] data_reg [NUM_CHAN];
  logic [DAC_WIDTH-1:0] latch [NUM_CHAN];
  logic [1:0] clr_a_sync;
  logic [1:0] clr_b_sync;
  logic [1:0] trig_sync;
  logic [1:0] gpio_sync;
  logic trig_prev;
  logic clr_a_prev;
  logic clr_b_prev;
  logic trigger_fall;
  logic clear_a;
  logic clear_b;
  logic [NUM_CHAN-1:0] chan_clear;
  logic [NUM_CHAN-1:0] chan_clear_prev;
  logic [NUM_CHAN-1:0] pending;
  logic setup_phase;
  logic wr_access;
  logic rd_access;
  logic mapped;
  logic load_pulse;
  logic result_read;
  logic busy;
  logic conv_done;
  logic [EV_WIDTH-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Edge detectors reset to the idle high level so reset gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_a_sync <= 2'h3;
      clr_b_sync <= 2'h3;
      trig_sync <= 2'h3;
      gpio_sync <= 2'h3;
      trig_prev <= 1'b1;
      clr_a_prev <= 1'b1;
      clr_b_prev <= 1'b1;
    end else begin
      clr_a_sync <= {clr_a_sync[0], clear_group_a_n};
      clr_b_sync <= {clr_b_sync[0], clear_group_b_n};
      trig_sync <= {trig_sync[0], conversion_trigger_n};
      gpio_sync <= {gpio_sync[0], sensor2_pos_or_gpio_in};
      trig_prev <= trig_sync[1];
      clr_a_prev <= clr_a_sync[1];
      clr_b_prev <= clr_b_sync[1];
    end
  end

  assign trigger_fall = trig_prev && !trig_sync[1];
  assign clear_a = !clr_a_sync[1];
  assign clear_b = !clr_b_sync[1];

  // Each channel follows the clear pin of its group
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chan_clear[i] = group_sel[i] ? clear_b : clear_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && mapped;
  assign rd_access = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign load_pulse = wr_access && (paddr == LOAD_OFFSET) && pwdata[0];
  assign result_read = rd_access && (paddr == RESULT_OFFSET);

  always_comb begin
    case (paddr)
      CTRL_OFFSET, GROUP_OFFSET, CODE_OFFSET, LOAD_OFFSET, INT_STATUS_OFFSET,
      INT_MASK_OFFSET, GPIO_OFFSET, STATUS_OFFSET, RESULT_OFFSET: mapped = 1'b1;
      default: mapped = in_bank(paddr, DATA_BASE) || in_bank(paddr, LATCH_BASE);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      case (paddr)
        CTRL_OFFSET: prdata <= 32'(ctrl);
        GROUP_OFFSET: prdata <= 32'(group_sel);
        CODE_OFFSET: prdata <= 32'(clear_code);
        INT_STATUS_OFFSET: prdata <= 32'(int_status);
        INT_MASK_OFFSET: prdata <= 32'(int_mask);
        GPIO_OFFSET: prdata <= 32'({gpio_sync[1], gpio_drive});
        STATUS_OFFSET: prdata <= 32'({!result_ready_n, busy, clear_b, clear_a});
        RESULT_OFFSET: prdata <= 32'(result);
        default: begin
          if (in_bank(paddr, DATA_BASE)) begin
            prdata <= 32'(data_reg[bank_index(paddr, DATA_BASE)]);
          end else if (in_bank(paddr, LATCH_BASE)) begin
            prdata <= 32'(latch[bank_index(paddr, LATCH_BASE)]);
          end else begin
            prdata <= '0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      group_sel <= GROUP_RESET;
      clear_code <= CODE_RESET;
      int_mask <= MASK_RESET;
      gpio_drive <= 1'b1;
    end else if (wr_access) begin
      case (paddr)
        CTRL_OFFSET: ctrl <= pwdata[CTRL_WIDTH-1:0];
        GROUP_OFFSET: group_sel <= pwdata[NUM_CHAN-1:0];
        CODE_OFFSET: clear_code <= pwdata[DAC_WIDTH-1:0];
        INT_MASK_OFFSET: int_mask <= pwdata[EV_WIDTH-1:0];
        GPIO_OFFSET: gpio_drive <= pwdata[0];
        default: begin
        end
      endcase
    end
  end

  // Data holding registers are written only by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        data_reg[i] <= DATA_RESET;
      end
    end else if (wr_access && in_bank(paddr, DATA_BASE)) begin
      data_reg[bank_index(paddr, DATA_BASE)] <= pwdata[DAC_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_clear_prev <= '0;
    end else begin
      chan_clear_prev <= chan_clear;
    end
  end

  // A write in synchronous mode waits here for the load command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_clear[i] || load_pulse) begin
          pending[i] <= 1'b0;
        end else if (wr_access && in_bank(paddr, DATA_BASE) &&
                     bank_index(paddr, DATA_BASE) == 4'(i)) begin
          pending[i] <= ctrl[CTRL_SYNC_LOAD_BIT];
        end
      end
    end
  end

  // Clear has priority; on release the latch takes the held data again
  // Only channels with a waiting write take the load command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        latch[i] <= DATA_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_clear[i]) begin
          latch[i] <= clear_code;
        end else if (chan_clear_prev[i]) begin
          latch[i] <= data_reg[i];
        end else if (!ctrl[CTRL_SYNC_LOAD_BIT]) begin
          latch[i] <= data_reg[i];
        end else if (load_pulse && pending[i]) begin
          latch[i] <= data_reg[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      dac_latch_flat[i*DAC_WIDTH +: DAC_WIDTH] = latch[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  adc_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .trigger_fall(trigger_fall),
    .auto_mode(ctrl[CTRL_AUTO_BIT]),
    .ready_enable(ctrl[CTRL_READY_EN_BIT]),
    .result_read(result_read),
    .busy(busy),
    .conv_done(conv_done),
    .result_ready_n(result_ready_n)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (conv_done) begin
      result <= adc_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared sensor / GPIO pin, open drain when used as GPIO
  assign sensor2_active = ctrl[CTRL_SENSOR2_EN_BIT];
  assign sensor2_pos_or_gpio_out = 1'b0;
  assign sensor2_pos_or_gpio_oe_n = sensor2_active || gpio_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  assign events[EV_CONV_DONE] = conv_done;
  assign events[EV_CLEAR_A] = clear_a && clr_a_prev;
  assign events[EV_CLEAR_B] = clear_b && clr_b_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else if (wr_access && paddr == INT_STATUS_OFFSET) begin
      int_status <= (int_status & ~pwdata[EV_WIDTH-1:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end

  assign irq = |(int_status & int_mask);
endmodule : dac_clear_ctrl
`default_nettype wire

// File: sim/dac_clear_ctrl_assertions.sv
// Checker for the clear, data-ready and shared pins
`timescale 1ns/1ps
`default_nettype none
module dac_clear_ctrl_assertions
  import dac_clear_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [ADDR_WIDTH-1:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic pready, // APB
  input wire logic clear_group_a_n, // Clear A
  input wire logic clear_group_b_n, // Clear B
  input wire logic result_ready_n, // Ready pin
  input wire logic sensor2_pos_or_gpio_oe_n, // Pin enable
  input wire logic sensor2_active, // Sensor route
  input wire logic [NUM_CHAN*DAC_WIDTH-1:0] dac_latch_flat // Latches
);
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [NUM_CHAN-1:0] grp;
  logic [DAC_WIDTH-1:0] code;
  logic gdrv;
  logic a_ok;
  logic b_ok;
  logic [CNT_WIDTH-1:0] low_cnt;
  wire acc = psel && penable;
  ////////////////////////////////////////////////////////////////
  // Shadow of the configuration written over APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      grp <= GROUP_RESET;
      code <= CODE_RESET;
      gdrv <= 1'b1;
    end else if (acc && pwrite) begin
      case (paddr)
        CTRL_OFFSET: ctrl <= pwdata[CTRL_WIDTH-1:0];
        GROUP_OFFSET: grp <= pwdata[NUM_CHAN-1:0];
        CODE_OFFSET: code <= pwdata[DAC_WIDTH-1:0];
        GPIO_OFFSET: gdrv <= pwdata[0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= '0;
    else if (result_ready_n) low_cnt <= '0;
    else low_cnt <= low_cnt + 1'b1;
  end
  always_comb begin
    a_ok = 1'b1;
    b_ok = 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (grp[i]) b_ok &= dac_latch_flat[i*DAC_WIDTH +: DAC_WIDTH] == code;
      else a_ok &= dac_latch_flat[i*DAC_WIDTH +: DAC_WIDTH] == code;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_apb_ready: assert property (pready == acc)
    else $error("pready not tied to access phase");
  chk_clear_a: assert property (!clear_group_a_n [*4] |-> a_ok)
    else $error("group a latch not at clear code");
  chk_clear_b: assert property (!clear_group_b_n [*4] |-> b_ok)
    else $error("group b latch not at clear code");
  chk_ready_off: assert property (!ctrl[CTRL_READY_EN_BIT] [*3] |-> result_ready_n)
    else $error("ready pin low while disabled");
  chk_auto_pulse: assert property (ctrl[CTRL_AUTO_BIT] && ctrl[CTRL_READY_EN_BIT]
    && $rose(result_ready_n) |-> low_cnt == PULSE_CYCLES)
    else $error("auto ready pulse has wrong width");
  chk_direct_hold: assert property (!ctrl[CTRL_AUTO_BIT] && ctrl[CTRL_READY_EN_BIT]
    && $stable(ctrl) && !result_ready_n && !(acc && paddr == RESULT_OFFSET)
    && !$past(acc && !pwrite && paddr == RESULT_OFFSET) |=> !result_ready_n)
    else $error("direct ready released without read");
  chk_sensor_route: assert property (sensor2_active == ctrl[CTRL_SENSOR2_EN_BIT])
    else $error("sensor route differs from control");
  chk_pin_release: assert property (!$past(acc && pwrite)
    |-> sensor2_pos_or_gpio_oe_n == (ctrl[CTRL_SENSOR2_EN_BIT] || gdrv))
    else $error("shared pin enable wrong");
endmodule : dac_clear_ctrl_assertions
bind dac_clear_ctrl dac_clear_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .clear_group_a_n(clear_group_a_n), .clear_group_b_n(clear_group_b_n),
  .result_ready_n(result_ready_n), .sensor2_pos_or_gpio_oe_n(sensor2_pos_or_gpio_oe_n),
  .sensor2_active(sensor2_active), .dac_latch_flat(dac_latch_flat));
`default_nettype wire

// File: sim/host_pins.sv
// Host-side pin model: clear and trigger drivers, shared pin pull-up
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic want_a, // Hold clear A
  input wire logic want_b, // Hold clear B
  input wire logic want_conv, // Trigger request
  input wire logic ext_low, // Outside pull-down
  input wire logic pin_oe_n, // Device enable
  input wire logic pin_out, // Device value
  input wire logic result_ready_n, // Ready pin
  output logic clear_group_a_n, // Clear A
  output logic clear_group_b_n, // Clear B
  output logic conversion_trigger_n, // Trigger
  output logic pin_level, // Shared pin
  output logic [15:0] ready_falls // Ready count
);
  logic ready_q;
  // Pull-up holds the line high unless someone drives it low
  assign pin_level = !((!pin_oe_n && !pin_out) || ext_low);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_group_a_n <= 1'b1;
      clear_group_b_n <= 1'b1;
      conversion_trigger_n <= 1'b1;
      ready_q <= 1'b1;
      ready_falls <= '0;
    end else begin
      clear_group_a_n <= !want_a;
      clear_group_b_n <= !want_b;
      conversion_trigger_n <= !want_conv;
      ready_q <= result_ready_n;
      ready_falls <= ready_falls + 16'(ready_q && !result_ready_n);
    end
  end
endmodule : host_pins
`default_nettype wire

// File: sim/tb_dac_clear_and_data_ready_pins.sv
// Self-checking bench for the clear, data-ready and shared pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_dac_clear_and_data_ready_pins;
  import dac_clear_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_WIDTH-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic want_a, want_b, want_conv, ext_low, clr_a_n, clr_b_n, trig_n, pin_lvl;
  logic pin_out, pin_oe_n, s2_act, irq, rdy_n;
  logic [DAC_WIDTH-1:0] adc_data, code, old;
  logic [NUM_CHAN*DAC_WIDTH-1:0] lat;
  logic [NUM_CHAN-1:0] grp;
  logic [DAC_WIDTH-1:0] data_q [NUM_CHAN];
  logic [15:0] rnd, falls, f0;
  int fail_count, n_checks, cyc;
  dac_clear_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_group_a_n(clr_a_n), .clear_group_b_n(clr_b_n),
    .conversion_trigger_n(trig_n), .adc_data(adc_data), .result_ready_n(rdy_n),
    .sensor2_pos_or_gpio_in(pin_lvl), .sensor2_pos_or_gpio_out(pin_out),
    .sensor2_pos_or_gpio_oe_n(pin_oe_n), .sensor2_active(s2_act), .dac_latch_flat(lat),
    .irq(irq));
  host_pins HOST (.pclk(pclk), .presetn(presetn), .want_a(want_a), .want_b(want_b),
    .want_conv(want_conv), .ext_low(ext_low), .pin_oe_n(pin_oe_n), .pin_out(pin_out),
    .result_ready_n(rdy_n), .clear_group_a_n(clr_a_n), .clear_group_b_n(clr_b_n),
    .conversion_trigger_n(trig_n), .pin_level(pin_lvl), .ready_falls(falls));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  function automatic logic [DAC_WIDTH-1:0] exp_lat(input int ch, input logic ia, input logic ib);
    return (grp[ch] ? ib : ia) ? code : data_q[ch];
  endfunction : exp_lat
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr_data(input int i, input logic [DAC_WIDTH-1:0] v);
    data_q[i] = v;
    apb(1'b1, 8'(DATA_BASE + 4 * i), {20'h0, v});
  endtask : wr_data
  task automatic wait_low;
    for (cyc = 0; cyc < 400 && rdy_n !== 1'b0; cyc++) @(posedge pclk);
    if (rdy_n !== 1'b0) begin
      fail_count++;
      close_out;
    end
  endtask : wait_low
  task automatic check_all(input logic ia, input logic ib);
    for (int i = 0; i < NUM_CHAN; i++)
      `CHK("latch", exp_lat(i, ia, ib), lat[i*DAC_WIDTH +: DAC_WIDTH])
  endtask : check_all
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (50000) @(posedge pclk);
    fail_count++;
    close_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, grp, code} = '0;
    {want_a, want_b, want_conv, ext_low, adc_data} = '0;
    fail_count = 0;
    n_checks = 0;
    rnd = 16'h0030;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("ready", 1'b1, rdy_n)
    apb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl", {28'h0, CTRL_RESET}, rdata)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    for (int i = 0; i < NUM_CHAN; i++) begin
      rnd = nx(rnd);
      wr_data(i, rnd[11:0]);
    end
    repeat (2) @(posedge pclk);
    check_all(1'b0, 1'b0);
    $display("test reset and load done");
    rnd = nx(rnd);
    grp = rnd[11:0] & 12'hffe | 12'h002;
    apb(1'b1, GROUP_OFFSET, {20'h0, grp});
    rnd = nx(rnd);
    code = rnd[11:0];
    apb(1'b1, CODE_OFFSET, {20'h0, code});
    want_a <= 1'b1;
    repeat (6) @(posedge pclk);
    check_all(1'b1, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK("status", 4'h1, rdata[3:0])
    wr_data(0, ~code);
    repeat (3) @(posedge pclk);
    check_all(1'b1, 1'b0);
    apb(1'b0, DATA_BASE, 32'h0);
    `CHK("data kept", {20'h0, ~code}, rdata)
    want_a <= 1'b0;
    repeat (6) @(posedge pclk);
    check_all(1'b0, 1'b0);
    $display("test clear a done");
    apb(1'b1, CTRL_OFFSET, 32'ha);
    old = lat[2*DAC_WIDTH-1:DAC_WIDTH];
    rnd = nx(rnd);
    wr_data(1, rnd[11:0]);
    `CHK("sync hold", old, lat[2*DAC_WIDTH-1:DAC_WIDTH])
    want_b <= 1'b1;
    repeat (6) @(posedge pclk);
    check_all(1'b0, 1'b1);
    apb(1'b1, LOAD_OFFSET, 32'h1);
    repeat (3) @(posedge pclk);
    check_all(1'b0, 1'b1);
    want_b <= 1'b0;
    repeat (6) @(posedge pclk);
    check_all(1'b0, 1'b0);
    apb(1'b0, INT_STATUS_OFFSET, 32'h0);
    `CHK("events", 2'b11, rdata[2:1])
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, INT_MASK_OFFSET, 32'h2);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, INT_STATUS_OFFSET, 32'h2);
    `CHK("irq cleared", 1'b0, irq)
    $display("test clear b done");
    apb(1'b1, CTRL_OFFSET, 32'h2);
    rnd = nx(rnd);
    adc_data <= rnd[11:0];
    want_conv <= 1'b1;
    wait_low;
    `CHK("conv time", 1'b1, cyc >= CONV_CYCLES)
    repeat (20) @(posedge pclk);
    `CHK("ready held", 1'b0, rdy_n)
    apb(1'b0, RESULT_OFFSET, 32'h0);
    `CHK("result", {20'h0, rnd[11:0]}, rdata)
    // The pin rises one edge after the read; look once it has settled
    @(posedge pclk);
    `CHK("ready freed", 1'b1, rdy_n)
    want_conv <= 1'b0;
    apb(1'b1, CTRL_OFFSET, 32'h3);
    want_conv <= 1'b1;
    wait_low;
    for (cyc = 0; cyc < 300 && rdy_n === 1'b0; cyc++) @(posedge pclk);
    `CHK("pulse", PULSE_CYCLES, cyc)
    wait_low;
    apb(1'b1, CTRL_OFFSET, 32'h0);
    f0 = falls;
    want_conv <= 1'b0;
    repeat (4) @(posedge pclk);
    want_conv <= 1'b1;
    repeat (700) @(posedge pclk);
    `CHK("no ready", f0, falls)
    $display("test convert done");
    for (int s = 0; s < 4; s++) begin
      ext_low <= (s == 1);
      apb(1'b1, CTRL_OFFSET, 32'(s[1]) << 2);
      apb(1'b1, GPIO_OFFSET, 32'(s[0]));
      repeat (4) @(posedge pclk);
      `CHK("route", s[1], s2_act)
      `CHK("oe", s[1] | s[0], pin_oe_n)
      apb(1'b0, GPIO_OFFSET, 32'h0);
      `CHK("level", (s[1] | s[0]) && s != 1, rdata[1])
    end
    $display("test pin done");
    close_out;
  end
endmodule : tb_dac_clear_and_data_ready_pins
`default_nettype wire
